// ---- src/analog_level_ramp_defines.vh ----
// constants shared by the analog level ramp block
// How it works
// - a rising enable loads offset plus start/stop offset, holds it one time base, then ramps.
// - a falling enable puts the level straight back to the offset, so the scaled output is 0.
// - level select low aims at target one, high aims at target two.
// - changing level select mid-ramp moves the level from where it is to the new target.
// - a rising decelerated stop moves the level at the set rate to the start/stop level.
// - once there, the start/stop level is held one time base and then the offset is loaded.
// - both target levels are limited to -10000 .. +20000.
// - the level never goes above the ceiling, which is limited to -10000 .. +20000.
// - the start/stop level is the offset plus a start/stop offset limited to 0 .. +20000.
// - the rate, in steps per second, is limited to 1 .. 10000.
// - the scaled output is level minus offset, divided by the gain.
// - the level steps only on the 100 ms time base.
// - after a stop, a new start needs both stop and enable to have gone low first.
// - the scaled output is limited to 0 .. +32767.
`ifndef ANALOG_LEVEL_RAMP_DEFINES_VH
`define ANALOG_LEVEL_RAMP_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define CLK_HZ 50000000
`define TICK_MS 100
// 100 ms of the 50 MHz clock, sized to the 23-bit time base counter
`define TICK_CYCLES_DEFAULT 23'h4c4b40

// ****************************************
// value ranges
// ****************************************
`define LEVEL_MIN (-18'sh02710)
`define LEVEL_MAX 18'sh04e20
`define OFFSET_MIN (-18'sh02710)
`define OFFSET_MAX 18'sh02710
`define SS_MIN 18'sh00000
`define SS_MAX 18'sh04e20
`define RATE_MIN 14'h0001
`define RATE_MAX 14'h2710
`define RATE_DIV 14'h000a
`define GAIN_MAX 10'h3e8
`define GAIN_SCALE 24'h000064
`define AQ_MAX 16'h7fff

// ****************************************
// reset values
// ****************************************
`define LEVEL_RESET 18'h00000
`define AQ_RESET 16'h0000

// ****************************************
// one-hot states
// ****************************************
`define ST_IDLE 6'h01
`define ST_START 6'h02
`define ST_RAMP 6'h04
`define ST_STOP_RAMP 6'h08
`define ST_STOP_HOLD 6'h10
`define ST_WAIT 6'h20

`endif

// ---- src/analog_level_ramp.v ----
// analog level ramp generator with scaled output
`timescale 1ns/1ns
`include "analog_level_ramp_defines.vh"

module analog_level_ramp #(
	parameter [22:0] TICK_CYCLES = `TICK_CYCLES_DEFAULT
) (
	input wire clk,
	input wire rst_n,
	input wire enable,
	input wire level_select,
	input wire decel_stop_request,
	input wire signed [15:0] level_one,
	input wire signed [15:0] level_two,
	input wire signed [15:0] level_ceiling,
	input wire [15:0] start_stop_offset,
	input wire [13:0] ramp_rate,
	input wire signed [15:0] level_offset,
	input wire [9:0] gain_hundredths,
	output reg signed [17:0] current_level_q,
	output reg [15:0] scaled_analog_out_q,
	output reg ramp_active_q
);

	localparam [5:0] ST_IDLE = `ST_IDLE;
	localparam [5:0] ST_START = `ST_START;
	localparam [5:0] ST_RAMP = `ST_RAMP;
	localparam [5:0] ST_STOP_RAMP = `ST_STOP_RAMP;
	localparam [5:0] ST_STOP_HOLD = `ST_STOP_HOLD;
	localparam [5:0] ST_WAIT = `ST_WAIT;
	localparam [22:0] TICK_LAST = TICK_CYCLES - 23'h000001;

	// ****************************************
	// helpers
	// ****************************************
	function signed [17:0] clamp;
		input signed [17:0] v;
		input signed [17:0] lo;
		input signed [17:0] hi;
		begin
			if (v < lo)
				clamp = lo;
			else if (v > hi)
				clamp = hi;
			else
				clamp = v;
		end
	endfunction

	function signed [17:0] sx;
		input [15:0] v;
		begin
			sx = {{2{v[15]}}, v};
		end
	endfunction

	// never passes the target, lands on it when close
	function signed [17:0] step_toward;
		input signed [17:0] cur;
		input signed [17:0] tgt;
		input signed [17:0] st;
		begin
			if (cur < tgt) begin
				if (tgt - cur <= st)
					step_toward = tgt;
				else
					step_toward = cur + st;
			end else begin
				if (cur - tgt <= st)
					step_toward = tgt;
				else
					step_toward = cur - st;
			end
		end
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	reg en_s1_q, en_s2_q, en_prev_q;
	reg sel_s1_q, sel_s2_q;
	reg stop_s1_q, stop_s2_q, stop_prev_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
			en_prev_q <= 1'b0;
			sel_s1_q <= 1'b0;
			sel_s2_q <= 1'b0;
			stop_s1_q <= 1'b0;
			stop_s2_q <= 1'b0;
			stop_prev_q <= 1'b0;
		end else begin
			en_s1_q <= enable;
			en_s2_q <= en_s1_q;
			en_prev_q <= en_s2_q;
			sel_s1_q <= level_select;
			sel_s2_q <= sel_s1_q;
			stop_s1_q <= decel_stop_request;
			stop_s2_q <= stop_s1_q;
			stop_prev_q <= stop_s2_q;
		end
	end

	wire en_rise = en_s2_q & ~en_prev_q;
	wire en_fall = ~en_s2_q & en_prev_q;
	wire stop_rise = stop_s2_q & ~stop_prev_q;

	// ****************************************
	// parameter limits
	// ****************************************
	// target limits
	wire signed [17:0] l1_c = clamp(sx(level_one), `LEVEL_MIN, `LEVEL_MAX);
	wire signed [17:0] l2_c = clamp(sx(level_two), `LEVEL_MIN, `LEVEL_MAX);
	wire signed [17:0] ceil_c = clamp(sx(level_ceiling), `LEVEL_MIN, `LEVEL_MAX);
	wire signed [17:0] off_c = clamp(sx(level_offset), `OFFSET_MIN, `OFFSET_MAX);
	wire signed [17:0] ss_c = clamp({2'b00, start_stop_offset}, `SS_MIN, `SS_MAX);
	wire signed [17:0] ss_sum = off_c + ss_c;
	wire signed [17:0] ss_level = (ss_sum > ceil_c) ? ceil_c : ss_sum;
	wire signed [17:0] tgt_raw = sel_s2_q ? l2_c : l1_c;
	wire signed [17:0] target = (tgt_raw > ceil_c) ? ceil_c : tgt_raw;
	wire [13:0] rate_c = (ramp_rate < `RATE_MIN) ? `RATE_MIN :
		(ramp_rate > `RATE_MAX) ? `RATE_MAX : ramp_rate;
	// tenth of rate per update; rates below ten still creep by one
	wire [13:0] rate_tenth = rate_c / `RATE_DIV;
	wire signed [17:0] step = (rate_tenth == 14'h0000) ? 18'sh00001 : {4'h0, rate_tenth};

	// ****************************************
	// time base
	// ****************************************
	reg [22:0] tick_cnt_q;
	reg restart;
	wire tick = (tick_cnt_q == TICK_LAST);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tick_cnt_q <= 23'h000000;
		else if (restart || tick)
			tick_cnt_q <= 23'h000000;
		else
			tick_cnt_q <= tick_cnt_q + 23'h000001;
	end

	// ****************************************
	// ramp state machine
	// ****************************************
	reg [5:0] state_q, state_d;
	reg signed [17:0] level_d;

	always @* begin
		state_d = state_q;
		level_d = current_level_q;
		restart = 1'b0;
		case (state_q)
			ST_IDLE: begin
				level_d = off_c;
				if (en_rise && !stop_s2_q) begin
					level_d = ss_level;
					restart = 1'b1;
					state_d = ST_START;
				end
			end
			ST_START: begin
				// first step at the end of the start hold, not one update later
				if (stop_rise) begin
					state_d = ST_STOP_RAMP;
				end else if (tick) begin
					level_d = step_toward(current_level_q, target, step);
					state_d = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (stop_rise)
					state_d = ST_STOP_RAMP;
				else if (tick)
					level_d = step_toward(current_level_q, target, step);
			end
			ST_STOP_RAMP: begin
				if (current_level_q == ss_level) begin
					restart = 1'b1;
					state_d = ST_STOP_HOLD;
				end else if (tick) begin
					level_d = step_toward(current_level_q, ss_level, step);
				end
			end
			ST_STOP_HOLD: begin
				if (tick) begin
					level_d = off_c;
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				level_d = off_c;
				if (!stop_s2_q && !en_s2_q)
					state_d = ST_IDLE;
			end
			default: begin
				level_d = off_c;
				state_d = ST_IDLE;
			end
		endcase
		if (en_fall && state_q != ST_IDLE) begin
			level_d = off_c;
			state_d = ST_WAIT;
		end
		// hard ceiling, also cuts in if ceiling is lowered mid-ramp
		if (level_d > ceil_c)
			level_d = ceil_c;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			current_level_q <= `LEVEL_RESET;
			ramp_active_q <= 1'b0;
		end else begin
			state_q <= state_d;
			current_level_q <= level_d;
			ramp_active_q <= (state_d != ST_IDLE) && (state_d != ST_WAIT);
		end
	end

	// ****************************************
	// scaled output
	// ****************************************
	// gain is in hundredths, so the difference is scaled by 100 first
	wire signed [17:0] diff = current_level_q - off_c;
	wire [23:0] prod = {7'h00, diff[16:0]} * `GAIN_SCALE;
	wire [23:0] quot = (gain_hundredths == 10'h000) ? 24'h000000 :
		prod / {14'h0000, gain_hundredths};
	reg [15:0] aq_d;

	always @* begin
		if (diff[17] || diff == 18'sh00000)
			aq_d = 16'h0000;
		else if (gain_hundredths == 10'h000 || quot > {8'h00, `AQ_MAX})
			aq_d = `AQ_MAX;
		else
			aq_d = quot[15:0];
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			scaled_analog_out_q <= `AQ_RESET;
		else
			scaled_analog_out_q <= aq_d;
	end

endmodule // analog_level_ramp

// ---- sim/program_inputs.sv ----
// controller-side model driving the ramp run inputs
`timescale 1ns/1ns
module program_inputs (
	input wire clk,
	input wire req_en,
	input wire req_sel,
	input wire req_stop,
	output logic enable = 1'b0,
	output logic level_select = 1'b0,
	output logic decel_stop_request = 1'b0
);
	logic [2:0] pend = 3'h0;
	// taken on the rising edge so the falling-edge drive never races the bench
	always @(posedge clk) begin
		pend <= {req_en, req_sel, req_stop};
	end
	always @(negedge clk) begin
		{enable, level_select, decel_stop_request} <= pend;
	end
endmodule // program_inputs

// ---- sim/ramp_chk.sv ----
// port checks for the analog level ramp
`timescale 1ns/1ns
module ramp_chk (
	input wire clk,
	input wire rst_n,
	input wire enable,
	input wire signed [15:0] level_ceiling,
	input wire [15:0] start_stop_offset,
	input wire [13:0] ramp_rate,
	input wire signed [15:0] level_offset,
	input wire [9:0] gain_hundredths,
	input wire signed [17:0] current_level_q,
	input wire [15:0] scaled_analog_out_q,
	input wire ramp_active_q
);
	logic signed [17:0] ss_sum;
	logic signed [17:0] ss_lvl;
	logic signed [17:0] step;
	assign ss_sum = level_offset + $signed({2'h0, start_stop_offset});
	assign ss_lvl = (ss_sum > level_ceiling) ? level_ceiling : ss_sum;
	assign step = (ramp_rate < 14'h000a) ? 18'sh00001 : $signed({4'h0, ramp_rate / 14'h000a});
	function automatic logic [15:0] aq_of(input logic signed [17:0] lv, input logic [9:0] g);
		logic signed [31:0] d;
		d = lv - level_offset;
		if (d <= 0) return 16'h0000;
		if (g == 10'h000) return 16'h7fff;
		d = d * 100 / $signed({22'h0, g});
		return (d > 32767) ? 16'h7fff : d[15:0];
	endfunction
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence start_held;
		$stable(current_level_q)[*8];
	endsequence
	a_fall_to_offset: assert property (
		$fell(enable) |-> ##[2:4] current_level_q == level_offset) else $error("level not offset");
	a_under_ceiling: assert property (
		current_level_q <= $past(level_ceiling)) else $error("level above ceiling");
	a_aq_range: assert property (
		scaled_analog_out_q <= 16'h7fff) else $error("scaled out of range");
	a_aq_formula: assert property (
		scaled_analog_out_q == aq_of($past(current_level_q), $past(gain_hundredths)))
		else $error("scaled value wrong");
	a_idle_offset: assert property (
		$past(rst_n) && !ramp_active_q |-> current_level_q == level_offset) else $error("idle not offset");
	a_start_level: assert property (
		$rose(ramp_active_q) |-> current_level_q == ss_lvl) else $error("start level wrong");
	a_start_hold: assert property (
		$rose(ramp_active_q) |=> start_held) else $error("start level not held");
	a_step_limit: assert property (
		ramp_active_q && $past(ramp_active_q) |-> current_level_q - $past(current_level_q) <= $past(step)
		&& $past(current_level_q) - current_level_q <= $past(step)) else $error("step too large");
endmodule // ramp_chk
bind analog_level_ramp ramp_chk i_chk (.clk(clk), .rst_n(rst_n), .enable(enable),
	.level_ceiling(level_ceiling), .start_stop_offset(start_stop_offset), .ramp_rate(ramp_rate),
	.level_offset(level_offset), .gain_hundredths(gain_hundredths),
	.current_level_q(current_level_q), .scaled_analog_out_q(scaled_analog_out_q),
	.ramp_active_q(ramp_active_q));

// ---- sim/testbench.sv ----
// self-checking bench for the analog level ramp
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_en = 1'b0;
	logic req_sel = 1'b0;
	logic req_stop = 1'b0;
	logic [9:0] gain = 10'h0c8;
	logic signed [15:0] level_one = 16'sh0bb8;
	logic signed [15:0] level_ceiling = 16'sh0a28;
	logic [13:0] ramp_rate = 14'h07d0;
	wire enable;
	wire level_select;
	wire decel_stop_request;
	wire signed [17:0] current_level_q;
	wire [15:0] scaled_analog_out_q;
	wire ramp_active_q;
	int failures = 0;
	int tests_run = 0;
	always #10 clk = ~clk;
	program_inputs i_drv (.clk(clk), .req_en(req_en), .req_sel(req_sel), .req_stop(req_stop),
		.enable(enable), .level_select(level_select), .decel_stop_request(decel_stop_request));
	analog_level_ramp #(.TICK_CYCLES(23'h000014)) i_dut (.clk(clk), .rst_n(rst_n), .enable(enable),
		.level_select(level_select), .decel_stop_request(decel_stop_request),
		.level_one(level_one), .level_two(16'sh07d0), .level_ceiling(level_ceiling),
		.start_stop_offset(16'h01f4), .ramp_rate(ramp_rate), .level_offset(16'sh03e8),
		.gain_hundredths(gain), .current_level_q(current_level_q),
		.scaled_analog_out_q(scaled_analog_out_q), .ramp_active_q(ramp_active_q));
	task final_report();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// bounded wait on the level or on the active flag
	task wait_for(input bit on_lvl, input logic [17:0] v, input int lim);
		int n;
		n = 0;
		while ((on_lvl ? current_level_q !== v : ramp_active_q !== v[0]) && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			failures++;
			$display("[ERR] wait expected %h seen %h", v,
				on_lvl ? current_level_q : {17'h0, ramp_active_q});
			final_report();
		end
	endtask
	initial begin
		cyc(10);
		rst_n = 1'b1;
		cyc(3);
		check("level", current_level_q, 18'h003e8);
		check("active", ramp_active_q, 18'h0);
		req_en = 1'b1;
		wait_for(0, 18'h1, 12);
		check("start", current_level_q, 18'h005dc);
		wait_for(1, 18'h00a28, 400);
		cyc(2);
		check("aq", scaled_analog_out_q, 18'h00320);
		gain = 10'h064;
		cyc(3);
		check("aq", scaled_analog_out_q, 18'h00640);
		cyc(60);
		check("ceiling", current_level_q, 18'h00a28);
		req_sel = 1'b1;
		wait_for(1, 18'h007d0, 400);
		cyc(60);
		check("target", current_level_q, 18'h007d0);
		req_stop = 1'b1;
		wait_for(1, 18'h005dc, 400);
		cyc(10);
		check("hold", {17'h0, ramp_active_q} ^ current_level_q, 18'h005dd);
		wait_for(0, 18'h0, 40);
		cyc(2);
		check("level", current_level_q, 18'h003e8);
		check("aq", scaled_analog_out_q, 18'h0);
		req_en = 1'b0;
		cyc(4);
		req_en = 1'b1;
		cyc(12);
		check("refused", ramp_active_q, 18'h0);
		req_stop = 1'b0;
		req_en = 1'b0;
		cyc(4);
		req_en = 1'b1;
		wait_for(0, 18'h1, 12);
		cyc(40);
		req_en = 1'b0;
		cyc(5);
		check("level", current_level_q, 18'h003e8);
		check("aq", scaled_analog_out_q, 18'h0);
		// out-of-range settings, changed while idle, must be clamped on the next run
		ramp_rate = 14'h3fff;
		level_ceiling = 16'sh7fff;
		level_one = 16'sh7fff;
		req_sel = 1'b0;
		cyc(4);
		req_en = 1'b1;
		wait_for(0, 18'h1, 12);
		wait_for(1, 18'h009c4, 60);
		wait_for(1, 18'h04e20, 500);
		cyc(2);
		check("aq", scaled_analog_out_q, 18'h04a38);
		gain = 10'h001;
		cyc(3);
		check("aq", scaled_analog_out_q, 18'h07fff);
		final_report();
	end
endmodule // testbench
